// file: rtl/gpio_port_pkg.sv
/*
 * Constants for the five-terminal general-purpose port: register offsets,
 * field widths, reset values and the secondary-function map.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
// Operation
// [RULE1] Direction bits 4..0 pick input (0, after reset) or output (1).
// [RULE2] A secondary-enabled terminal ignores its direction bit.
// [RULE3] Terminals 0,1,3,4 carry clock run, power override, data, clock.
// [RULE4] A data read returns the synced level of each input terminal.
// [RULE5] A data write drives each output terminal to the written level.
// [RULE6] Data writes to input or secondary-enabled terminals are dropped.
// [RULE7] Bits 15..5 of both registers read zero and ignore writes.
// [RULE8] Any of the three resets clears direction and data bits.
// [RULE9] After power-up every terminal is an input; data reads show pins.
// [RULE10] Terminal levels pass a two-flop synchroniser before they are read.
package gpio_port_pkg;

   // ==========================================================
   // Register map
   localparam logic [7:0]  DIR_OFFSET   = 8'hb4;
   localparam logic [7:0]  DATA_OFFSET  = 8'hb6;
   localparam int          REG_WIDTH    = 16;
   localparam int          PIN_COUNT    = 5;

   // ==========================================================
   // Reset values and secondary-function map
   localparam logic [4:0]  DIR_RESET    = 5'h00;
   localparam logic [4:0]  LATCH_RESET  = 5'h00;
   localparam logic [4:0]  SEC_CAPABLE  = 5'h1b;  // Terminal 2 has none
   localparam logic [10:0] RSVD_VALUE   = 11'h000;

   typedef logic [PIN_COUNT-1:0] pins_t;
   typedef logic [REG_WIDTH-1:0] word_t;

endpackage : gpio_port_pkg

// file: rtl/level_sync_if.sv
/*
 * Carrier between the port top and its synchroniser: raw pin levels in,
 * clean levels out.
 * Assumes both ends run on mclk.
 */
`timescale 1ns/1ps
`default_nettype none
interface level_sync_if;
   import gpio_port_pkg::*;
   pins_t raw;
   pins_t synced;
   modport owner  (output raw, input synced);
   modport syncer (input raw, output synced);
endinterface : level_sync_if
`default_nettype wire

// file: rtl/pin_sync.sv
/*
 * Two-flop synchroniser for the five terminal input levels.
 * Assumes the raw levels are asynchronous to mclk.
 */
`timescale 1ns/1ps
`default_nettype none
module pin_sync
(
   input  wire logic         mclk,   // 100 MHz clock
   input  wire logic         rst_b,  // Async reset, active low
   level_sync_if.syncer      lvl     // Raw in, synced out
);
   import gpio_port_pkg::*;

   typedef struct packed {
      pins_t stage1;
      pins_t stage2;
   } sync_state_s;

   sync_state_s state;
   sync_state_s next_state;

   // ==========================================================
   // Stage one feeds only stage two, never any logic
   always_comb
   begin
      next_state        = state;
      next_state.stage1 = lvl.raw;        // see [RULE10]
      next_state.stage2 = state.stage1;
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         state <= '0;
      else
         state <= next_state;
   end

   assign lvl.synced = state.stage2;

   chk_sync_two_flops: assert property (@(posedge mclk) disable iff (!rst_b)
      $past(rst_b, 2) |-> lvl.synced == $past(lvl.raw, 2)) // see [RULE10]
      else $error("synced level not raw level two clocks late");

endmodule : pin_sync
`default_nettype wire

// file: rtl/gpio_port.sv
/*
 * Five-terminal general-purpose port with a direction register and a
 * data register in configuration space. Terminals 0, 1, 3 and 4 may be
 * handed to secondary functions, which then own both level and drive.
 * Assumes rst_b already merges the fundamental, global and power-on
 * resets, and that secondary-function controls run on mclk.
 * Assumes the pad ring turns terminal_o and terminal_oe into a pin and
 * feeds the pad level back on terminal_i with no clock relation.
 */
`timescale 1ns/1ps
`default_nettype none
module gpio_port
(
   input  wire logic                  mclk,         // 100 MHz clock
   input  wire logic                  rst_b,        // Async reset, low
   input  wire logic [7:0]            cfg_addr,     // Config byte offset
   input  wire logic                  cfg_wr,       // Write strobe
   input  wire logic                  cfg_rd,       // Read strobe
   input  wire gpio_port_pkg::word_t  cfg_wdata,    // Write data
   output logic                       cfg_rvalid,   // Read data valid
   output gpio_port_pkg::word_t       cfg_rdata,    // Read data
   input  wire gpio_port_pkg::pins_t  sec_enable,   // Secondary enables
   input  wire gpio_port_pkg::pins_t  sec_out,      // Secondary levels
   input  wire gpio_port_pkg::pins_t  sec_oe,       // Secondary drives
   output gpio_port_pkg::pins_t       sec_in,       // Synced pins
   input  wire gpio_port_pkg::pins_t  terminal_i,   // Pin levels in
   output gpio_port_pkg::pins_t       terminal_o,   // Pin levels out
   output gpio_port_pkg::pins_t       terminal_oe   // Pin drive enable
);
   import gpio_port_pkg::*;

   // ==========================================================
   // Module state: both registers, the read answer and pin drivers.
   // One flop bank keeps every output registered.
   typedef struct packed {
      pins_t dir;
      pins_t latch;
      word_t rdata;
      logic  rvalid;
      pins_t pin_o;
      pins_t pin_oe;
      pins_t sec_seen;
   } port_state_s;

   port_state_s state;
   port_state_s next_state;
   level_sync_if lvl ();

   // Per-terminal decode shared by the write, read and drive paths
   pins_t sec_active;
   pins_t writable;
   pins_t read_bits;

   // ==========================================================
   // Input synchroniser
   assign lvl.raw = terminal_i;

   pin_sync u_sync
   (
      .mclk  (mclk),
      .rst_b (rst_b),
      .lvl   (lvl)
   );

   // ==========================================================
   // Ownership of each terminal
   always_comb
   begin
      sec_active = sec_enable & SEC_CAPABLE;             // see [RULE3]
      writable   = state.dir & ~sec_active;              // see [RULE6]
      // Output bits not owned by a secondary function show the latch, others the pin itself
      read_bits  = (writable & state.latch)
                 | (~writable & lvl.synced);             // see [RULE4]
   end

   // ==========================================================
   // Registers, read path and pin drivers
   always_comb
   begin
      next_state        = state;
      // Read answer lasts one cycle; idle cycles show zero
      next_state.rvalid = cfg_rd;
      next_state.rdata  = '0;
      // Direction keeps writes even for secondary-owned terminals
      if (cfg_wr && cfg_addr == DIR_OFFSET)
         next_state.dir = cfg_wdata[PIN_COUNT-1:0];      // see [RULE1]
      if (cfg_wr && cfg_addr == DATA_OFFSET)
         // Masked bits keep their old value
         next_state.latch = (cfg_wdata[PIN_COUNT-1:0] & writable)
                          | (state.latch & ~writable);   // see [RULE5]
      // Unmapped offsets answer zero with a valid pulse
      if (cfg_rd && cfg_addr == DIR_OFFSET)
         next_state.rdata = {RSVD_VALUE, state.dir};     // see [RULE7]
      else if (cfg_rd && cfg_addr == DATA_OFFSET)
         next_state.rdata = {RSVD_VALUE, read_bits};     // see [RULE7]
      // Secondary function owns its terminal, direction ignored
      next_state.pin_oe = (sec_active & sec_oe)
                        | (~sec_active & next_state.dir); // see [RULE2]
      next_state.pin_o  = (sec_active & sec_out)
                        | (~sec_active & next_state.latch);
      // Copy for secondary blocks, one flop after the synchroniser
      next_state.sec_seen = lvl.synced;
   end

   // Reset leaves every terminal an undriven input
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         // Constants only, so the async path needs no logic
         state       <= '0;
         state.dir   <= DIR_RESET;                       // see [RULE8]
         state.latch <= LATCH_RESET;                     // see [RULE9]
      end
      else
         state <= next_state;
   end

   // ==========================================================
   // Outputs straight from flops
   assign cfg_rdata   = state.rdata;
   assign cfg_rvalid  = state.rvalid;
   assign terminal_o  = state.pin_o;
   assign terminal_oe = state.pin_oe;
   assign sec_in      = state.sec_seen;

   // ==========================================================
   // Checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);

   chk_dir_write_sets: assert property ( // see [RULE1]
      cfg_wr && cfg_addr == DIR_OFFSET
      |=> state.dir == $past(cfg_wdata[4:0]))
      else $error("direction write not stored");

   chk_sec_owns_pin: assert property ( // see [RULE2]
      sec_enable[0] |=> terminal_oe[0] == $past(sec_oe[0])
                    && terminal_o[0] == $past(sec_out[0]))
      else $error("secondary function lost terminal 0");

   chk_pin2_no_sec: assert property ( // see [RULE3]
      sec_enable[2] && !cfg_wr
      |=> terminal_oe[2] == state.dir[2])
      else $error("terminal 2 taken by a secondary function");

   chk_read_inputs: assert property ( // see [RULE4]
      cfg_rd && cfg_addr == DATA_OFFSET && state.dir == 5'h00
      |=> cfg_rvalid && cfg_rdata[4:0] == $past(lvl.synced))
      else $error("input level not returned on read");

   chk_write_drives: assert property ( // see [RULE5]
      cfg_wr && cfg_addr == DATA_OFFSET && writable[1]
      ##1 !sec_enable[1]
      |-> terminal_o[1] == $past(cfg_wdata[1]) && terminal_oe[1])
      else $error("output terminal not driven to written level");

   chk_write_ignored: assert property ( // see [RULE6]
      cfg_wr && cfg_addr == DATA_OFFSET && !writable[3]
      |=> $stable(state.latch[3]))
      else $error("write to non-output bit took effect");

   chk_rsvd_zero: assert property ( // see [RULE7]
      cfg_rdata[15:5] == 11'h000)
      else $error("reserved bits not zero");

   chk_reset_inputs: assert property ( // see [RULE8]
      $rose(rst_b) |-> terminal_oe == 5'h00 && state.dir == 5'h00
                    && state.latch == 5'h00)
      else $error("terminal driven right after reset");

   chk_rvalid_pulse: assert property ( // see [RULE4]
      !cfg_rd |=> !cfg_rvalid [*1] ##0 cfg_rdata == 16'h0000)
      else $error("read data without a read");

   // ==========================================================
   // Read answer checks

   // Every read strobe is answered on the next edge
   chk_rvalid_follows: assert property ( // see [RULE4]
      cfg_rd |=> cfg_rvalid)
      else $error("read strobe got no answer");

   // Direction reads show the stored bits over a zero upper field
   chk_dir_read_back: assert property ( // see [RULE1]
      cfg_rd && cfg_addr == DIR_OFFSET
      |=> cfg_rdata == {RSVD_VALUE, $past(state.dir)})
      else $error("direction read does not match stored bits");

   // Offsets beside the two registers answer zero
   chk_unmapped_zero: assert property ( // see [RULE7]
      cfg_rd && cfg_addr != DIR_OFFSET && cfg_addr != DATA_OFFSET
      |=> cfg_rvalid && cfg_rdata == 16'h0000)
      else $error("unmapped read returned data");

   // Terminal 2 has no secondary use, so an input read shows its pin
   chk_pin2_synced_read: assert property ( // see [RULE10]
      cfg_rd && cfg_addr == DATA_OFFSET && !state.dir[2]
      |=> cfg_rdata[2] == $past(lvl.synced[2]))
      else $error("terminal 2 read bypassed the synchroniser");

   // ==========================================================
   // Drive and ownership checks

   // Idle bus and no secondary use: drivers mirror the registers
   chk_oe_follows_dir: assert property ( // see [RULE1]
      sec_enable == 5'h00 && !cfg_wr
      |=> terminal_oe == $past(state.dir))
      else $error("drive enable does not follow direction");

   chk_latch_drives: assert property ( // see [RULE5]
      sec_enable == 5'h00 && !cfg_wr
      |=> terminal_o == $past(state.latch))
      else $error("pin level does not follow data latch");

   // Only writable bits may change on a data write
   chk_write_masked: assert property ( // see [RULE6]
      cfg_wr && cfg_addr == DATA_OFFSET
      |=> ((state.latch ^ $past(state.latch)) & ~$past(writable))
          == 5'h00)
      else $error("data write reached a protected bit");

   // ==========================================================
   // Reset and synchroniser checks

   // No drive before software asks for one
   chk_power_up_inputs: assert property ( // see [RULE9]
      $rose(rst_b) && !cfg_wr && sec_enable == 5'h00
      |=> terminal_oe == 5'h00)
      else $error("terminal driven before any direction write");

   // Secondary copy trails the synchroniser by one flop
   chk_sec_in_lag: assert property ( // see [RULE10]
      sec_in == $past(lvl.synced))
      else $error("secondary level copy out of step");

endmodule : gpio_port
`default_nettype wire

// file: sim/board_pins.sv
/*
 * Board model for the five port terminals.
 * Assumes the port drives a pin only while its enable is high.
 */
`timescale 1ns/1ps
`default_nettype none
module board_pins
(
   input  wire gpio_port_pkg::pins_t terminal_o,  // Port drive level
   input  wire gpio_port_pkg::pins_t terminal_oe, // Port drive enable
   input  wire gpio_port_pkg::pins_t board_lvl,   // Board level
   output gpio_port_pkg::pins_t      terminal_i   // Resolved pin
);
   // ==========================================================
   // Port wins where it drives; the board holds every other pin
   assign terminal_i = (terminal_o & terminal_oe) |
                       (board_lvl & ~terminal_oe);
endmodule : board_pins
`default_nettype wire

// file: sim/gpio_port_tb.sv
/*
 * Self-checking bench for the general-purpose port.
 * Assumes the board model resolves each pin from both drivers.
 */
`timescale 1ns/1ps
`default_nettype none
module gpio_port_tb;
   import gpio_port_pkg::*;
   logic mclk, rst_b, cfg_wr, cfg_rd, cfg_rvalid;
   logic [7:0] cfg_addr;
   word_t cfg_wdata, cfg_rdata;
   pins_t sec_enable, sec_out, sec_oe, sec_in;
   pins_t terminal_i, terminal_o, terminal_oe, board_lvl;
   int n_mismatch, checks_done, cycles;

   gpio_port dut (.mclk(mclk), .rst_b(rst_b), .cfg_addr(cfg_addr),
      .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_wdata(cfg_wdata),
      .cfg_rvalid(cfg_rvalid), .cfg_rdata(cfg_rdata),
      .sec_enable(sec_enable), .sec_out(sec_out), .sec_oe(sec_oe),
      .sec_in(sec_in), .terminal_i(terminal_i),
      .terminal_o(terminal_o), .terminal_oe(terminal_oe));
   board_pins board (.terminal_o(terminal_o), .terminal_oe(terminal_oe),
      .board_lvl(board_lvl), .terminal_i(terminal_i));

   // ==========================================================
   // Clock and hang guard; ceiling far above the short test list
   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   always @(posedge mclk)
   begin
      cycles = cycles + 1;
      if (cycles == 2000)
      begin
         n_mismatch = n_mismatch + 1;
         report_and_stop();
      end
   end

   // ==========================================================
   // Helpers; inputs move 1 ns after the edge
   task tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : tick
   task chk(input string what, input word_t exp, input word_t got);
      checks_done = checks_done + 1;
      if (got !== exp)
      begin
         n_mismatch = n_mismatch + 1;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task cfg_write(input logic [7:0] a, input word_t d);
      cfg_addr = a;
      cfg_wdata = d;
      cfg_wr = 1'b1;
      tick(1);
      cfg_wr = 1'b0;
      // Idle edge so back-to-back calls never reassign a strobe at once
      tick(1);
   endtask : cfg_write
   task cfg_read(input logic [7:0] a, input word_t exp);
      cfg_addr = a;
      cfg_rd = 1'b1;
      tick(1);
      cfg_rd = 1'b0;
      chk("rvalid", 16'h0001, {15'h0000, cfg_rvalid});
      chk("rdata", exp, cfg_rdata);
      // Idle edge so back-to-back calls never reassign a strobe at once
      tick(1);
   endtask : cfg_read
   task report_and_stop();
      $display("Comparisons %0d, mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : report_and_stop

   // ==========================================================
   // Main sequence
   initial
   begin
      {n_mismatch, checks_done, cycles} = '0;
      {rst_b, cfg_wr, cfg_rd, cfg_addr, cfg_wdata} = '0;
      {sec_enable, sec_out, sec_oe} = '0;
      board_lvl = 5'h15;
      tick(12);
      rst_b = 1'b1;
      tick(2);
      cfg_read(DIR_OFFSET, 16'h0000);
      chk("oe", 16'h0000, {11'h000, terminal_oe});
      cfg_read(DATA_OFFSET, 16'h0015);
      cfg_write(DIR_OFFSET, 16'hffff);
      cfg_read(DIR_OFFSET, 16'h001f);
      cfg_write(DATA_OFFSET, 16'hffea);
      chk("pins", 16'h000a, {11'h000, terminal_o});
      cfg_read(DATA_OFFSET, 16'h000a);
      cfg_write(DIR_OFFSET, 16'h0003);
      cfg_write(DATA_OFFSET, 16'h001f);
      cfg_read(DATA_OFFSET, 16'h0017);
      cfg_write(DIR_OFFSET, 16'h001f);
      chk("latch", 16'h000b, {11'h000, terminal_o});
      // Secondary functions take over all but terminal 2
      sec_enable = 5'h1f;
      sec_oe = 5'h1b;
      sec_out = 5'h11;
      tick(2);
      chk("sec oe", 16'h001f, {11'h000, terminal_oe});
      chk("sec o", 16'h0011, {11'h000, terminal_o});
      sec_oe = 5'h00;
      tick(2);
      chk("sec off", 16'h0004, {11'h000, terminal_oe});
      cfg_write(DATA_OFFSET, 16'h001f);
      sec_enable = 5'h00;
      tick(2);
      chk("after sec", 16'h000f, {11'h000, terminal_o});
      cfg_read(8'hb5, 16'h0000);
      // Reset in mid-run must drop every drive
      rst_b = 1'b0;
      tick(2);
      rst_b = 1'b1;
      tick(2);
      chk("rst oe", 16'h0000, {11'h000, terminal_oe});
      cfg_read(DIR_OFFSET, 16'h0000);
      board_lvl = 5'h0a;
      tick(2);
      cfg_read(DATA_OFFSET, 16'h000a);
      chk("sec in", 16'h000a, {11'h000, sec_in});
      // Latch must be back at its reset level once driven again
      cfg_write(DIR_OFFSET, 16'h001f);
      chk("rst latch", 16'h0000, {11'h000, terminal_o});
      report_and_stop();
   end
endmodule : gpio_port_tb
`default_nettype wire
